// ### rtl/asl_pkg.sv
package asl_pkg;

  // system clock rate and led slot time
  localparam int CLK_MHZ = 50;
  localparam int LED_SLOT_US = 1000;
  localparam int LED_SLOT_CYCLES = LED_SLOT_US * CLK_MHZ;
  localparam int SLOT_W = 16;

  // frame positions, counted in received bits
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_STEP = 5'h01;
  localparam logic [4:0] CNT_ADDR_DONE = 5'h01;
  localparam logic [4:0] CNT_FLAG_FIRST = 5'h02;
  localparam logic [4:0] CNT_CMD_LAST = 5'h07;
  localparam logic [4:0] CNT_DATA_FIRST = 5'h08;
  localparam logic [4:0] CNT_LAST = 5'h0F;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [3:0] FLAG_IDX_BASE = 4'h9;

  // command byte fields
  localparam int CMD_W_BIT = 0;
  localparam int CMD_REG_LSB = 1;
  localparam int CMD_REG_MSB = 5;

  // register offsets
  localparam logic [4:0] REG_SNAPSHOT = 5'h00;
  localparam logic [4:0] REG_FAULT = 5'h01;
  localparam logic [4:0] REG_LED = 5'h02;
  localparam logic [4:0] REG_GCFG = 5'h03;

  // global_config fields
  localparam int GCFG_CLR_POLICY = 0;
  localparam int GCFG_OUT_MODE = 1;
  localparam int GCFG_AUTO_IND = 2;
  localparam int GCFG_LED9 = 3;

  // primary_fault_flags fields
  localparam int F_CRC = 7;
  localparam int F_POR = 6;
  localparam int F_SECONDARY_FAULT_SUMMARY = 5;
  localparam int F_TEMP = 4;
  localparam int F_FIELD_SUPPLY_UNDERVOLT_FLAG = 3;
  localparam int F_MONITOR_VOLTAGE_LOW_FLAG = 2;
  localparam int F_OTS1 = 1;

  // reset values and masks
  localparam logic [7:0] FAULT_RESET = 8'h40;
  localparam logic [7:0] LED_RESET = 8'h00;
  localparam logic [7:0] GCFG_RESET = 8'h00;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_ALL = 8'hFF;
  localparam logic [7:0] MASK_KEEP_OTS1 = 8'hFD;

  // led matrix rows, one-hot
  localparam int ROW_LSB = 3;
  typedef enum logic [2:0] {
    ROW_A = 3'b001,
    ROW_B = 3'b010,
    ROW_C = 3'b100
  } asl_row_type;

endpackage : asl_pkg

// ### rtl/asl_spi_top.sv
`timescale 1ns/1ps

module asl_spi_top #(
  parameter int LED_SLOT_CYCLES = asl_pkg::LED_SLOT_CYCLES
) (
  // system clock, enable and reset
  input wire logic clock,
  input wire logic clk_en,
  input wire logic rst_b,
  // spi link
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_b,
  // straps and mode pin
  input wire logic addr_strap_high,
  input wire logic addr_strap_low,
  input wire logic chain_select,
  // input sensing and snapshot
  input wire logic [7:0] input_state_bits,
  input wire logic snapshot_latch_b,
  // fault sources
  input wire logic crc_error_event,
  input wire logic secondary_fault_summary,
  input wire logic temperature_alarm,
  input wire logic field_supply_undervolt,
  input wire logic monitor_voltage_low,
  input wire logic thermal_shutdown_level1,
  input wire logic thermal_shutdown_level2,
  // logic outputs
  output logic [5:0] logic_output_pins,
  output logic [5:0] logic_output_oe_b
);

  localparam int SW = asl_pkg::SLOT_W;
  localparam logic [SW-1:0] SLOT_LAST = SW'(LED_SLOT_CYCLES - 1);
  localparam logic [SW-1:0] SLOT_ZERO = '0;

  // link domain state
  logic [4:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] cmd_q;
  logic match_q;
  logic [7:0] led_q;
  logic [7:0] gcfg_q;
  logic done_tgl_q;
  logic clr_cmd_q;
  logic clr_read_q;
  logic sdo_q;
  logic sdo_oe_b_q;
  logic [4:0] reg_sel;
  logic [7:0] rdata;
  logic [7:0] word;
  logic out_bit;

  // system domain state
  logic cs_s, latch_s, daisy_s, ots1_s, ots2_s;
  logic [1:0] strap_s;
  logic [7:0] in_s;
  logic f2_s, temp_s, uv_s, vml_s;
  logic [7:0] led_s;
  logic [7:0] gcfg_s;
  logic done_s, clr_cmd_s, clr_read_s;
  logic cs_prev_q, latch_prev_q, done_prev_q, pend_q;
  logic [7:0] snap_q;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] hold_q;
  logic [7:0] clr_mask;
  logic [7:0] set_vec;
  logic [SW-1:0] slot_q;
  asl_pkg::asl_row_type row_q;
  logic [8:0] led_vec;
  logic [2:0] cols;
  logic [5:0] lo_q;
  logic [5:0] lo_oe_b_q;

  // pins from outside, all but the crc event, sclk and sdi, pass three stages
  asl_sync #(.WIDTH(19)) u_pin_sync (
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .d({cs_b, snapshot_latch_b, chain_select, addr_strap_high,
        addr_strap_low, input_state_bits, secondary_fault_summary,
        temperature_alarm, field_supply_undervolt, monitor_voltage_low,
        thermal_shutdown_level1, thermal_shutdown_level2}),
    .q({cs_s, latch_s, daisy_s, strap_s, in_s, f2_s, temp_s, uv_s,
        vml_s, ots1_s, ots2_s})
  );

  // link registers are quasi-static levels, crossed the same way
  asl_sync #(.WIDTH(19)) u_link_sync (
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .d({led_q, gcfg_q, done_tgl_q, clr_cmd_q, clr_read_q}),
    .q({led_s, gcfg_s, done_s, clr_cmd_s, clr_read_s})
  );

  // frame shifter; chip select high holds it cleared
  // idle frame ignored
  always_ff @(posedge sclk or posedge cs_b)
  begin
    if (cs_b)
    begin
      cnt_q <= asl_pkg::CNT_ZERO;
      sh_q <= 8'h00;
      cmd_q <= 8'h00;
      match_q <= 1'b0;
    end
    else
    begin
      if (cnt_q != asl_pkg::FRAME_BITS)
        cnt_q <= cnt_q + asl_pkg::CNT_STEP;
      sh_q <= {sh_q[6:0], sdi};
      if (cnt_q == asl_pkg::CNT_ADDR_DONE)
        match_q <= daisy_s | ({sh_q[0], sdi} == strap_s);
      if (cnt_q == asl_pkg::CNT_CMD_LAST)
        cmd_q <= {sh_q[6:0], sdi};
    end
  end

  assign reg_sel = cmd_q[asl_pkg::CMD_REG_MSB:asl_pkg::CMD_REG_LSB];

  // config registers live on the link clock so a read needs no crossing;
  // straps and daisy are static, so reading them here is safe
  // writable configuration
  always_ff @(posedge sclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      led_q <= asl_pkg::LED_RESET;
      gcfg_q <= asl_pkg::GCFG_RESET;
      done_tgl_q <= 1'b0;
      clr_cmd_q <= 1'b0;
      clr_read_q <= 1'b0;
    end
    else if (cnt_q == asl_pkg::CNT_LAST && match_q)
    begin
      done_tgl_q <= ~done_tgl_q;
      clr_cmd_q <= !daisy_s && !gcfg_q[asl_pkg::GCFG_CLR_POLICY];
      clr_read_q <= !daisy_s && gcfg_q[asl_pkg::GCFG_CLR_POLICY] &&
                    !cmd_q[asl_pkg::CMD_W_BIT] &&
                    reg_sel == asl_pkg::REG_FAULT;
      if (cmd_q[asl_pkg::CMD_W_BIT])
      begin
        case (reg_sel)
          asl_pkg::REG_LED: led_q <= {sh_q[6:0], sdi};
          asl_pkg::REG_GCFG: gcfg_q <= {sh_q[6:0], sdi};
          default: ;
        endcase
      end
    end
  end

  // serial answer bit for the current position
  always_comb
  begin
    case (reg_sel)
      asl_pkg::REG_SNAPSHOT: rdata = snap_q;
      asl_pkg::REG_FAULT: rdata = hold_q;
      asl_pkg::REG_LED: rdata = led_q;
      asl_pkg::REG_GCFG: rdata = gcfg_q;
      default: rdata = 8'h00;
    endcase
    word = cmd_q[asl_pkg::CMD_W_BIT] ? snap_q : rdata;
    if (cnt_q < asl_pkg::CNT_DATA_FIRST)
      out_bit = hold_q[3'(asl_pkg::FLAG_IDX_BASE - cnt_q[3:0])];
    else
      out_bit = word[~cnt_q[2:0]];
  end

  // sdo changes on fall; released outside an addressed frame
  // released while deselected
  always_ff @(negedge sclk or posedge cs_b)
  begin
    if (cs_b)
    begin
      sdo_q <= 1'b0;
      sdo_oe_b_q <= 1'b1;
    end
    else if (match_q && cnt_q >= asl_pkg::CNT_FLAG_FIRST &&
             cnt_q < asl_pkg::FRAME_BITS)
    begin
      sdo_q <= out_bit;
      sdo_oe_b_q <= 1'b0;
    end
    else
    begin
      sdo_oe_b_q <= 1'b1;
    end
  end

  assign sdo = sdo_q;
  assign sdo_oe_b = sdo_oe_b_q;

  // edge memories in the system domain
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      cs_prev_q <= 1'b0;
      latch_prev_q <= 1'b0;
      done_prev_q <= 1'b0;
      pend_q <= 1'b0;
    end
    else if (clk_en)
    begin
      cs_prev_q <= cs_s;
      latch_prev_q <= latch_s;
      done_prev_q <= done_s;
      // kind bits settle one cycle after the toggle at worst
      pend_q <= done_s ^ done_prev_q;
    end
  end

  // snapshot of inputs and fault flags for the next frame
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      snap_q <= 8'h00;
      hold_q <= asl_pkg::FAULT_RESET;
    end
    else if (clk_en)
    begin
      if (latch_prev_q && !latch_s)
        snap_q <= in_s;
      else if (cs_prev_q && !cs_s && latch_s)
        snap_q <= in_s;
      if (cs_prev_q && !cs_s)
        hold_q <= flags_q;
    end
  end

  // only flags that were reported can be cleared, so none is lost
  always_comb
  begin
    set_vec = asl_pkg::MASK_NONE;
    set_vec[asl_pkg::F_CRC] = crc_error_event;
    set_vec[asl_pkg::F_SECONDARY_FAULT_SUMMARY] = f2_s;
    set_vec[asl_pkg::F_TEMP] = temp_s;
    set_vec[asl_pkg::F_FIELD_SUPPLY_UNDERVOLT_FLAG] = uv_s;
    set_vec[asl_pkg::F_MONITOR_VOLTAGE_LOW_FLAG] = vml_s;
    set_vec[asl_pkg::F_OTS1] = ots1_s;
    if (pend_q && clr_cmd_s)
      clr_mask = asl_pkg::MASK_KEEP_OTS1 & hold_q;
    else if (pend_q && clr_read_s)
      clr_mask = asl_pkg::MASK_ALL & hold_q;
    else
      clr_mask = asl_pkg::MASK_NONE;
    // a set in the clearing cycle wins
    flags_d = (flags_q & ~clr_mask) | set_vec;
  end

  // sticky primary fault flags, power-on flag set by reset
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      flags_q <= asl_pkg::FAULT_RESET;
    else if (clk_en)
      flags_q <= flags_d;
  end

  // row slot timer
  // 1 ms slots
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      slot_q <= SLOT_ZERO;
      row_q <= asl_pkg::ROW_A;
    end
    else if (clk_en)
    begin
      if (slot_q == SLOT_LAST)
      begin
        slot_q <= SLOT_ZERO;
        case (row_q)
          asl_pkg::ROW_A: row_q <= asl_pkg::ROW_B;
          asl_pkg::ROW_B: row_q <= asl_pkg::ROW_C;
          asl_pkg::ROW_C: row_q <= asl_pkg::ROW_A;
          default: row_q <= asl_pkg::ROW_A;
        endcase
      end
      else
        slot_q <= slot_q + SW'(1);
    end
  end

  // led sources and the columns of the active row
  always_comb
  begin
    if (gcfg_s[asl_pkg::GCFG_AUTO_IND])
      led_vec = {vml_s, in_s};
    else
      led_vec = {gcfg_s[asl_pkg::GCFG_LED9], led_s};
    case (row_q)
      asl_pkg::ROW_A: cols = led_vec[2:0];
      asl_pkg::ROW_B: cols = led_vec[5:3];
      asl_pkg::ROW_C: cols = led_vec[8:6];
      default: cols = 3'h0;
    endcase
  end

  // logic output pins, registered
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      lo_q <= 6'h00;
      lo_oe_b_q <= 6'h3F;
    end
    else if (clk_en)
    begin
      if (gcfg_s[asl_pkg::GCFG_OUT_MODE])
      begin
        lo_q <= led_s[5:0];
        lo_oe_b_q <= {6{ots2_s}};
      end
      else
      begin
        lo_oe_b_q <= 6'h00;
        if (ots1_s)
          lo_q <= 6'h38;
        else
          lo_q <= {~row_q, cols};
      end
    end
  end

  assign logic_output_pins = lo_q;
  assign logic_output_oe_b = lo_oe_b_q;

  // checks on the link side
  chk_idle_release:
  assert property (@(posedge clock) disable iff (!rst_b)
    cs_b |-> sdo_oe_b_q)
    else $error("sdo driven while deselected");

  chk_addr_match:
  assert property (@(posedge sclk) disable iff (cs_b)
    (cnt_q == asl_pkg::CNT_ADDR_DONE && !daisy_s) |=>
    match_q == (strap_s == {$past(sh_q[0]), $past(sdi)}))
    else $error("address compare wrong");

  chk_chain_match:
  assert property (@(posedge sclk) disable iff (cs_b)
    (cnt_q == asl_pkg::CNT_ADDR_DONE && daisy_s) |=> match_q)
    else $error("chain frame not taken");

  chk_foreign_quiet:
  assert property (@(negedge sclk) disable iff (cs_b)
    !match_q |=> sdo_oe_b_q)
    else $error("sdo driven for other target");

  // judged at the last fall: no rise follows the write inside the frame
  chk_write_done:
  assert property (@(negedge sclk) disable iff (cs_b)
    (cnt_q == asl_pkg::FRAME_BITS && match_q && cmd_q[asl_pkg::CMD_W_BIT]
     && reg_sel == asl_pkg::REG_GCFG) |-> gcfg_q == sh_q)
    else $error("config write lost");

  // checks on the system side
  chk_row_step:
  assert property (@(posedge clock) disable iff (!rst_b)
    (clk_en && slot_q == SLOT_LAST) |=> row_q != $past(row_q))
    else $error("row did not advance");

  chk_slot_hold:
  assert property (@(posedge clock) disable iff (!rst_b)
    (clk_en && slot_q != SLOT_LAST) |=> row_q == $past(row_q))
    else $error("row moved early");

  chk_gpo_off:
  assert property (@(posedge clock) disable iff (!rst_b)
    (clk_en && gcfg_s[asl_pkg::GCFG_OUT_MODE] && ots2_s)
    |=> lo_oe_b_q == 6'h3F)
    else $error("gpo driven in shutdown");

  chk_matrix_dark:
  assert property (@(posedge clock) disable iff (!rst_b)
    (clk_en && !gcfg_s[asl_pkg::GCFG_OUT_MODE] && ots1_s)
    |=> lo_q[2:0] == 3'h0)
    else $error("matrix lit in shutdown");

  chk_ots1_kept:
  assert property (@(posedge clock) disable iff (!rst_b)
    (clk_en && pend_q && clr_cmd_s && flags_q[asl_pkg::F_OTS1])
    |=> flags_q[asl_pkg::F_OTS1])
    else $error("thermal flag cleared by command");

  cov_write_frame: cover property (@(posedge sclk)
    cnt_q == asl_pkg::CNT_LAST && match_q && cmd_q[asl_pkg::CMD_W_BIT]);
  cov_fault_read: cover property (@(posedge clock) pend_q && clr_read_s);
  cov_latch_freeze: cover property (@(posedge clock)
    latch_prev_q && !latch_s);
  cov_row_wrap: cover property (@(posedge clock)
    clk_en && slot_q == SLOT_LAST && row_q == asl_pkg::ROW_C);

endmodule : asl_spi_top

// ### rtl/asl_sync.sv
`timescale 1ns/1ps

module asl_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  // crossing data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // three stages; a bit counts once stages two and three agree
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q <= '0;
    end
    else if (clk_en)
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & q);
    end
  end

endmodule : asl_sync

// ### tb/asl_ctrl_model.sv
`timescale 1ns/1ps

module asl_ctrl_model (
  // spi link driven by the controller
  output logic sclk,
  output logic cs_b,
  output logic sdi,
  // target answer
  input wire logic sdo,
  input wire logic sdo_oe_b
);
  localparam int HALF = 24;
  localparam int GAP = 240;

  // idle: clock parked low, deselected
  initial
  begin
    sclk = 1'b0;
    cs_b = 1'b0;
    sdi = 1'b0;
    // a real rising select edge clears the frame logic at start
    #5;
    cs_b = 1'b1;
  end

  // one whole frame; rx and oe hold what was seen at each rise
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] rx,
                      output logic [15:0] oe);
    int i;
    // stray clock while deselected must be ignored
    sclk = 1'b1;
    #HALF;
    sclk = 1'b0;
    #HALF;
    cs_b = 1'b0;
    // gap lets the target copy inputs and flags through its synchroniser
    #GAP;
    for (i = 15; i >= 0; i--)
    begin
      // address bits lead, then command, msb first
      sdi = cmd[i];
      // mode zero, 48 ns period stays under the rate limit
      #HALF;
      sclk = 1'b1;
      // sample on the rise, the target moved sdo on the fall
      // a released line reads inverted, so a late enable corrupts data
      rx[i] = sdo_oe_b ? ~sdo : sdo;
      oe[i] = sdo_oe_b;
      #HALF;
      sclk = 1'b0;
    end
    // released line shows the inverse, never a stale bit
    sdi = ~sdi;
    #HALF;
    cs_b = 1'b1;
    #GAP;
  endtask : xfer

endmodule : asl_ctrl_model

// ### tb/asl_spi_top_tb.sv
`timescale 1ns/1ps

module asl_spi_top_tb;
  localparam int SLOT = 8;
  logic clock, clk_en, rst_b, sclk, cs_b, sdi, sdo, sdo_oe_b;
  logic chain_select, latch_b, ots1, ots2;
  logic [1:0] strap;
  logic [4:0] fsrc;
  logic [7:0] din;
  logic [5:0] pins, pins_oe_b;
  logic [15:0] rx, oe, flg, dat;
  int fails, checked;

  // device with a short led slot to keep the run brief
  asl_spi_top #(.LED_SLOT_CYCLES(SLOT)) dut (
    .clock(clock), .clk_en(clk_en), .rst_b(rst_b),
    .sclk(sclk), .cs_b(cs_b), .sdi(sdi), .sdo(sdo), .sdo_oe_b(sdo_oe_b),
    .addr_strap_high(strap[1]), .addr_strap_low(strap[0]),
    .chain_select(chain_select), .input_state_bits(din),
    .snapshot_latch_b(latch_b), .crc_error_event(fsrc[4]),
    .secondary_fault_summary(fsrc[3]), .temperature_alarm(fsrc[2]),
    .field_supply_undervolt(fsrc[1]), .monitor_voltage_low(fsrc[0]),
    .thermal_shutdown_level1(ots1), .thermal_shutdown_level2(ots2),
    .logic_output_pins(pins), .logic_output_oe_b(pins_oe_b));

  asl_ctrl_model ctrl (.sclk(sclk), .cs_b(cs_b), .sdi(sdi), .sdo(sdo),
    .sdo_oe_b(sdo_oe_b));

  // system clock
  initial clock = 1'b0;
  always #10 clock = ~clock;

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic clocks(input int n);
    repeat (n) @(negedge clock);
  endtask : clocks

  task automatic frame(input logic [1:0] a, input logic [4:0] r,
                       input logic w, input logic [7:0] d, input logic hit);
    ctrl.xfer({a, r, w, d}, rx, oe);
    flg = {10'h000, rx[13:8]};
    dat = {8'h00, rx[7:0]};
    check("sdo enable", oe, hit ? 16'hC000 : 16'hFFFF);
    check("sdo idle", {15'h0000, sdo_oe_b}, 16'h0001);
  endtask : frame

  task automatic rd(input logic [4:0] r);
    frame(strap, r, 1'b0, 8'h00, 1'b1);
  endtask : rd

  task automatic wr(input logic [4:0] r, input logic [7:0] d);
    frame(strap, r, 1'b1, d, 1'b1);
  endtask : wr

  // level fault sources are held long enough to cross three flops
  task automatic pulse(input logic [4:0] v);
    clocks(1);
    fsrc = v;
    clocks(10);
    fsrc = 5'h00;
    clocks(10);
  endtask : pulse

  task automatic t_por;
    rd(asl_pkg::REG_FAULT);
    check("por flag", flg, 16'h0010);
    check("fault value", dat, 16'h0040);
    rd(asl_pkg::REG_FAULT);
    check("flags cleared", flg, 16'h0000);
    rd(asl_pkg::REG_GCFG);
    check("config reset", dat, 16'h0000);
    $display("test por done");
  endtask : t_por

  task automatic t_regs;
    clocks(1);
    din = 8'hC3;
    clocks(5);
    wr(asl_pkg::REG_LED, 8'h5A);
    check("write inputs", dat, 16'h00C3);
    rd(asl_pkg::REG_LED);
    check("led readback", dat, 16'h005A);
    wr(asl_pkg::REG_GCFG, 8'hF0);
    rd(asl_pkg::REG_GCFG);
    check("config readback", dat, 16'h00F0);
    wr(asl_pkg::REG_SNAPSHOT, 8'hFF);
    rd(asl_pkg::REG_SNAPSHOT);
    check("snapshot ro", dat, 16'h00C3);
    rd(5'h1F);
    check("unmapped", dat, 16'h0000);
    wr(asl_pkg::REG_GCFG, 8'h00);
    $display("test regs done");
  endtask : t_regs

  // each strap value, with a foreign frame that must change nothing
  task automatic t_addr;
    for (int a = 0; a < 4; a++)
    begin
      clocks(1);
      strap = a[1:0];
      clocks(5);
      wr(asl_pkg::REG_LED, {6'h00, a[1:0]});
      pulse(5'h04);
      frame(strap ^ 2'b01, asl_pkg::REG_LED, 1'b1, 8'hEE, 1'b0);
      rd(asl_pkg::REG_LED);
      check("own write", dat, {14'h0000, a[1:0]});
      check("flag kept", flg, 16'h0004);
    end
    clocks(1);
    strap = 2'b00;
    $display("test addr done");
  endtask : t_addr

  task automatic t_faults;
    logic [4:0] v;
    for (int k = 0; k < 5; k++)
    begin
      v = 5'h01 << k;
      pulse(v);
      rd(asl_pkg::REG_LED);
      check("flag order", flg, {10'h000, v[4], 1'b0, v[3:0]});
      rd(asl_pkg::REG_LED);
      check("flag cleared", flg, 16'h0000);
    end
    clocks(1);
    ots1 = 1'b1;
    clocks(10);
    for (int n = 0; n < 3 * SLOT; n++)
    begin
      check("matrix dark", {10'h000, pins}, 16'h0038);
      clocks(1);
    end
    ots1 = 1'b0;
    clocks(10);
    rd(asl_pkg::REG_FAULT);
    rd(asl_pkg::REG_FAULT);
    check("level1 kept", dat, 16'h0002);
    wr(asl_pkg::REG_GCFG, 8'h01);
    pulse(5'h04);
    wr(asl_pkg::REG_LED, 8'h00);
    rd(asl_pkg::REG_LED);
    check("policy one kept", flg, 16'h0004);
    rd(asl_pkg::REG_FAULT);
    check("policy one value", dat, 16'h0012);
    rd(asl_pkg::REG_FAULT);
    check("read clears", dat, 16'h0000);
    wr(asl_pkg::REG_GCFG, 8'h00);
    $display("test faults done");
  endtask : t_faults

  task automatic t_snap;
    clocks(1);
    din = 8'h11;
    clocks(5);
    latch_b = 1'b0;
    clocks(5);
    din = 8'h22;
    clocks(5);
    rd(asl_pkg::REG_SNAPSHOT);
    check("latched", dat, 16'h0011);
    clocks(1);
    latch_b = 1'b1;
    clocks(5);
    rd(asl_pkg::REG_SNAPSHOT);
    check("cs sampled", dat, 16'h0022);
    $display("test snap done");
  endtask : t_snap

  task automatic t_chain;
    clocks(1);
    chain_select = 1'b1;
    clocks(5);
    pulse(5'h04);
    frame(2'b11, asl_pkg::REG_LED, 1'b1, 8'h3C, 1'b1);
    frame(2'b10, asl_pkg::REG_LED, 1'b0, 8'h00, 1'b1);
    check("chain no clear", flg, 16'h0004);
    check("chain write", dat, 16'h003C);
    clocks(1);
    chain_select = 1'b0;
    clocks(5);
    rd(asl_pkg::REG_LED);
    rd(asl_pkg::REG_LED);
    check("addressable clear", flg, 16'h0000);
    $display("test chain done");
  endtask : t_chain

  // lock onto the start of row A, then walk all three slots
  task automatic show(input logic [8:0] leds);
    logic [2:0] row;
    for (int n = 0; n < 4 * SLOT && pins[5:3] !== 3'b011; n++) clocks(1);
    for (int n = 0; n < 4 * SLOT && pins[5:3] !== 3'b110; n++) clocks(1);
    for (int r = 0; r < 3; r++)
    begin
      row = ~(3'b001 << r);
      repeat (SLOT)
      begin
        check("matrix", {4'h0, pins_oe_b, pins},
              {10'h000, row, leds[3 * r +: 3]});
        clocks(1);
      end
    end
  endtask : show

  task automatic t_matrix;
    wr(asl_pkg::REG_LED, 8'h5A);
    wr(asl_pkg::REG_GCFG, 8'h08);
    clocks(10);
    show({1'b1, 8'h5A});
    din = 8'hA5;
    fsrc = 5'h01;
    wr(asl_pkg::REG_GCFG, 8'h04);
    clocks(10);
    show({1'b1, 8'hA5});
    fsrc = 5'h00;
    $display("test matrix done");
  endtask : t_matrix

  task automatic t_gpo;
    wr(asl_pkg::REG_LED, 8'h2D);
    wr(asl_pkg::REG_GCFG, 8'h02);
    clocks(10);
    check("gpo drive", {4'h0, pins_oe_b, pins}, 16'h002D);
    ots2 = 1'b1;
    clocks(10);
    check("gpo off", {10'h000, pins_oe_b}, 16'h003F);
    ots2 = 1'b0;
    clocks(10);
    check("gpo back", {4'h0, pins_oe_b, pins}, 16'h002D);
    wr(asl_pkg::REG_GCFG, 8'h00);
    $display("test gpo done");
  endtask : t_gpo

  // a low enable must hold every system-side flop, rows included
  task automatic t_freeze;
    logic [5:0] held;
    clocks(1);
    held = pins;
    clk_en = 1'b0;
    din = 8'h00;
    for (int n = 0; n < 3 * SLOT; n++)
    begin
      clocks(1);
      check("frozen", {10'h000, pins}, {10'h000, held});
    end
    clk_en = 1'b1;
    clocks(10);
    $display("test freeze done");
  endtask : t_freeze

  task automatic complete_run;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // main sequence
  initial
  begin
    fails = 0;
    checked = 0;
    rst_b = 1'b1;
    clk_en = 1'b1;
    chain_select = 1'b0;
    latch_b = 1'b1;
    ots1 = 1'b0;
    ots2 = 1'b0;
    strap = 2'b00;
    fsrc = 5'h00;
    din = 8'h00;
    // a real falling reset edge so the link registers clear too
    @(negedge clock);
    rst_b = 1'b0;
    clocks(10);
    rst_b = 1'b1;
    clocks(10);
    t_por;
    t_regs;
    t_addr;
    t_faults;
    t_snap;
    t_chain;
    t_matrix;
    t_freeze;
    t_gpo;
    complete_run;
  end

  // watchdog: about fifty frames of 1.3 us plus waits, with wide margin
  initial
  begin
    #400000;
    fails++;
    $display("FAIL watchdog expected finish seen hang");
    complete_run;
  end

endmodule : asl_spi_top_tb
